// ==== rtc_irq_pkg.sv ====
package rtc_irq_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned FAST_PERIOD_NS = 977_000;
  localparam int unsigned SLOW_PERIOD_MS = 500;
  localparam int unsigned MEAS_PERIOD_MS = 1000;
  localparam int unsigned CE_HOLD_ON_MS = 2500;
  localparam int unsigned CE_HOLD_OFF_MS = 1500;
  localparam int unsigned NS_PER_MS = 1_000_000;
  localparam int unsigned FAST_HALF_CYC = FAST_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int unsigned SLOW_HALF_CYC = SLOW_PERIOD_MS * (NS_PER_MS / (2 * CLK_PERIOD_NS));
  localparam int unsigned MEAS_HALF_CYC = MEAS_PERIOD_MS * (NS_PER_MS / (2 * CLK_PERIOD_NS));
  localparam int unsigned CE_HOLD_ON_CYC = CE_HOLD_ON_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int unsigned CE_HOLD_OFF_CYC = CE_HOLD_OFF_MS * (NS_PER_MS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Interrupt cycle select field
  // ----------------------------------------------------------------
  localparam int unsigned CYCLE_W = 4;
  localparam int unsigned LEVEL_MODE_BIT = 3;
  localparam logic [3:0] CYCLE_RESET = 4'h0;
  localparam logic [1:0] PULSE_OFF = 2'h0;
  localparam logic [1:0] PULSE_ON = 2'h1;
  localparam logic [1:0] PULSE_FAST = 2'h2;
  localparam logic [1:0] PULSE_SLOW = 2'h3;
  localparam logic [2:0] LEVEL_SEC = 3'h0;
  localparam logic [2:0] LEVEL_10SEC = 3'h1;
  localparam logic [2:0] LEVEL_MIN = 3'h2;
  localparam logic [2:0] LEVEL_10MIN = 3'h3;
  localparam logic [2:0] LEVEL_HOUR = 3'h4;
  localparam logic [2:0] LEVEL_DAY = 3'h5;
  localparam logic [2:0] LEVEL_WEEK = 3'h6;
  localparam logic [2:0] LEVEL_MONTH = 3'h7;

  // ----------------------------------------------------------------
  // Calendar field widths (BCD)
  // ----------------------------------------------------------------
  localparam int unsigned WDAY_W = 3;
  localparam int unsigned HOUR_W = 6;
  localparam int unsigned MIN_W = 7;
  localparam int unsigned SEC_W = 7;
  localparam int unsigned DAY_W = 6;
  localparam logic [5:0] FIRST_DAY = 6'h01;
endpackage

// ==== wave_if.sv ====
`timescale 1ns/1ps
interface wave_if;
  logic clk;
  logic rst;
  logic run;
  logic wave;
  modport gen (input clk, input rst, input run, output wave);
  modport user (output clk, output rst, output run, input wave);
endinterface

// ==== half_period_gen.sv ====
`timescale 1ns/1ps
module half_period_gen
  import rtc_irq_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = 2
)
(
  wave_if.gen w
);
  logic [31:0] count;

  // ----------------------------------------------------------------
  // Square wave, low while stopped so each start begins on a full half
  // ----------------------------------------------------------------
  always_ff @(posedge w.clk)
  begin
    if (w.rst || !w.run)
    begin
      count <= 32'h0000_0000;
      w.wave <= 1'b0;
    end
    else if (count == HALF_CYCLES - 1)
    begin
      count <= 32'h0000_0000;
      w.wave <= ~w.wave;
    end
    else
    begin
      count <= count + 32'h0000_0001;
    end
  end
endmodule // half_period_gen

// ==== rtc_irq_top.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Alarm weekday, hour and minute equal to calendar pulls the interrupt low.
// - A programmed periodic cycle pulls the interrupt low each period.
// - Suppress bit at 1 keeps alarm matches off the interrupt pin.
// - Both interrupt sources work regardless of chip select level.
// - Alarm output depends jointly on alarm enable and alarm flag.
// - Alarm flag reads 1 while the alarm drives the pin low.
// - Top cycle bit picks pulse mode at 0, level mode at 1.
// - Pulse mode ignores bit 2; 00 releases, 01 holds low.
// - Pulse mode 10 toggles at 0.977 ms period, 11 at 0.5 s period.
// - Level codes: each second, ten seconds, minute, ten minutes.
// - Level codes: hourly, daily midnight, weekly weekday zero, monthly day one.
// - In pulse mode periodic flag mirrors output and ignores writes.
// - In level mode writing periodic flag 1 forces low, 0 releases.
// - Chip select held high 2.5 s gives 1 Hz pulses on the pin.
// - Chip select high under 1.5 s gives no measurement pulse.
module rtc_irq_top
  import rtc_irq_pkg::*;
#(
  parameter int unsigned FAST_HALF = FAST_HALF_CYC,
  parameter int unsigned SLOW_HALF = SLOW_HALF_CYC,
  parameter int unsigned MEAS_HALF = MEAS_HALF_CYC,
  parameter int unsigned CE_HOLD_ON = CE_HOLD_ON_CYC
)
(
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  input wire logic SEC_TICK_I,
  input wire logic [WDAY_W-1:0] CAL_WEEKDAY_I,
  input wire logic [HOUR_W-1:0] CAL_HOUR_I,
  input wire logic [MIN_W-1:0] CAL_MINUTE_I,
  input wire logic [SEC_W-1:0] CAL_SECOND_I,
  input wire logic [DAY_W-1:0] CAL_DAY_I,
  input wire logic [WDAY_W-1:0] ALARM_WEEKDAY_I,
  input wire logic [HOUR_W-1:0] ALARM_HOUR_I,
  input wire logic [MIN_W-1:0] ALARM_MINUTE_I,
  input wire logic ALARM_ENABLE_I,
  input wire logic ALARM_OUTPUT_SUPPRESS_I,
  input wire logic [CYCLE_W-1:0] CYCLE_WDATA_I,
  input wire logic CYCLE_WR_I,
  input wire logic ALARM_FLAG_WR_I,
  input wire logic ALARM_FLAG_WDATA_I,
  input wire logic PERIODIC_FLAG_WR_I,
  input wire logic PERIODIC_FLAG_WDATA_I,
  output logic [CYCLE_W-1:0] INTERRUPT_CYCLE_SELECT_O,
  output logic ALARM_HIT_FLAG_O,
  output logic PERIODIC_HIT_FLAG_O,
  output logic IRQ_OUT_N_O,
  output logic IRQ_OE_O
);
  logic [CYCLE_W-1:0] interrupt_cycle_select;
  logic ce_meta;
  logic ce_sync;
  logic [31:0] ce_hold_count;
  logic meas_on;
  logic alarm_match;
  logic alarm_match_d;
  logic alarm_hit_flag;
  logic periodic_hit_flag;
  logic periodic_level_mode_sel;
  logic [1:0] pulse_code;
  logic pulse_out;
  logic level_boundary;
  logic alarm_req;
  logic periodic_req;
  logic next_irq;

  wave_if fast_w ();
  wave_if slow_w ();
  wave_if meas_w ();

  // ----------------------------------------------------------------
  // Period boundary decode
  // ----------------------------------------------------------------
  function automatic logic period_hit(input logic [2:0] sel, input logic [SEC_W-1:0] sec,
                                      input logic [MIN_W-1:0] mins, input logic [HOUR_W-1:0] hr,
                                      input logic [WDAY_W-1:0] wday, input logic [DAY_W-1:0] day);
    logic s0;
    logic m0;
    logic h0;
    s0 = (sec == '0);
    m0 = (mins == '0);
    h0 = (hr == '0);
    case (sel)
      LEVEL_SEC: period_hit = 1'b1;
      LEVEL_10SEC: period_hit = (sec[3:0] == 4'h0);
      LEVEL_MIN: period_hit = s0;
      LEVEL_10MIN: period_hit = s0 && (mins[3:0] == 4'h0);
      LEVEL_HOUR: period_hit = s0 && m0;
      LEVEL_DAY: period_hit = s0 && m0 && h0;
      LEVEL_WEEK: period_hit = s0 && m0 && h0 && (wday == '0);
      LEVEL_MONTH: period_hit = s0 && m0 && h0 && (day == FIRST_DAY);
      default: period_hit = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Cycle select register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
      interrupt_cycle_select <= CYCLE_RESET;
    else if (CYCLE_WR_I)
      interrupt_cycle_select <= CYCLE_WDATA_I;
  end

  assign periodic_level_mode_sel = interrupt_cycle_select[LEVEL_MODE_BIT];
  assign pulse_code = interrupt_cycle_select[1:0];

  // ----------------------------------------------------------------
  // Chip select hold timer
  // ----------------------------------------------------------------
  // Chip select is a pin: two flops before use
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      ce_meta <= 1'b0;
      ce_sync <= 1'b0;
    end
    else
    begin
      ce_meta <= CE_I;
      ce_sync <= ce_meta;
    end
  end

  // Any drop of chip select restarts the hold, so short holds never emit
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I || !ce_sync)
    begin
      ce_hold_count <= 32'h0000_0000;
      meas_on <= 1'b0;
    end
    else if (ce_hold_count < CE_HOLD_ON - 1)
      ce_hold_count <= ce_hold_count + 32'h0000_0001;
    else
      meas_on <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Wave generators
  // ----------------------------------------------------------------
  assign fast_w.clk = CLK_I;
  assign fast_w.rst = RESET_I;
  assign fast_w.run = !periodic_level_mode_sel && (pulse_code == PULSE_FAST);
  assign slow_w.clk = CLK_I;
  assign slow_w.rst = RESET_I;
  assign slow_w.run = !periodic_level_mode_sel && (pulse_code == PULSE_SLOW);
  assign meas_w.clk = CLK_I;
  assign meas_w.rst = RESET_I;
  assign meas_w.run = meas_on;

  half_period_gen #(.HALF_CYCLES(FAST_HALF)) u_fast (.w(fast_w));
  half_period_gen #(.HALF_CYCLES(SLOW_HALF)) u_slow (.w(slow_w));
  half_period_gen #(.HALF_CYCLES(MEAS_HALF)) u_meas (.w(meas_w));

  always_comb
  begin
    case (pulse_code)
      PULSE_OFF: pulse_out = 1'b0;
      PULSE_ON: pulse_out = 1'b1;
      PULSE_FAST: pulse_out = fast_w.wave;
      PULSE_SLOW: pulse_out = slow_w.wave;
      default: pulse_out = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Alarm source
  // ----------------------------------------------------------------
  assign alarm_match = (ALARM_WEEKDAY_I == CAL_WEEKDAY_I) && (ALARM_HOUR_I == CAL_HOUR_I)
                       && (ALARM_MINUTE_I == CAL_MINUTE_I);

  // Edge of the match, so a match standing when enable rises is not taken
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
      alarm_match_d <= 1'b0;
    else
      alarm_match_d <= alarm_match;
  end

  // Set wins over a clearing write in the same cycle
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
      alarm_hit_flag <= 1'b0;
    else if (ALARM_ENABLE_I && alarm_match && !alarm_match_d)
      alarm_hit_flag <= 1'b1;
    else if (ALARM_FLAG_WR_I)
      alarm_hit_flag <= ALARM_FLAG_WDATA_I;
  end

  assign alarm_req = ALARM_ENABLE_I && alarm_hit_flag && !ALARM_OUTPUT_SUPPRESS_I;

  // ----------------------------------------------------------------
  // Periodic source
  // ----------------------------------------------------------------
  assign level_boundary = SEC_TICK_I && period_hit(interrupt_cycle_select[2:0], CAL_SECOND_I,
                          CAL_MINUTE_I, CAL_HOUR_I, CAL_WEEKDAY_I, CAL_DAY_I);

  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
      periodic_hit_flag <= 1'b0;
    else if (!periodic_level_mode_sel)
      periodic_hit_flag <= pulse_out;
    else if (level_boundary)
      periodic_hit_flag <= 1'b1;
    else if (PERIODIC_FLAG_WR_I)
      periodic_hit_flag <= PERIODIC_FLAG_WDATA_I;
  end

  assign periodic_req = periodic_level_mode_sel ? periodic_hit_flag : pulse_out;
  assign next_irq = alarm_req || periodic_req || (meas_on && meas_w.wave);

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      IRQ_OUT_N_O <= 1'b1;
      IRQ_OE_O <= 1'b0;
      ALARM_HIT_FLAG_O <= 1'b0;
      PERIODIC_HIT_FLAG_O <= 1'b0;
      INTERRUPT_CYCLE_SELECT_O <= CYCLE_RESET;
    end
    else
    begin
      IRQ_OUT_N_O <= !next_irq;
      IRQ_OE_O <= next_irq;
      ALARM_HIT_FLAG_O <= alarm_hit_flag && ALARM_ENABLE_I;
      PERIODIC_HIT_FLAG_O <= periodic_hit_flag;
      INTERRUPT_CYCLE_SELECT_O <= interrupt_cycle_select;
    end
  end
endmodule // rtc_irq_top

// ==== irq_pullup_host.sv ====
`timescale 1ns/1ps
module irq_pullup_host
(
  input wire logic oe_i,
  output logic pin_o
);
  // Pull-up: a released line reads high, never the last driven value
  assign pin_o = oe_i ? 1'b0 : 1'b1;
endmodule // irq_pullup_host

// ==== rtc_irq_sva.sv ====
`timescale 1ns/1ps
module rtc_irq_sva
  import rtc_irq_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  input wire logic SEC_TICK_I,
  input wire logic [WDAY_W-1:0] CAL_WEEKDAY_I,
  input wire logic [HOUR_W-1:0] CAL_HOUR_I,
  input wire logic [MIN_W-1:0] CAL_MINUTE_I,
  input wire logic [WDAY_W-1:0] ALARM_WEEKDAY_I,
  input wire logic [HOUR_W-1:0] ALARM_HOUR_I,
  input wire logic [MIN_W-1:0] ALARM_MINUTE_I,
  input wire logic ALARM_ENABLE_I,
  input wire logic ALARM_OUTPUT_SUPPRESS_I,
  input wire logic [CYCLE_W-1:0] CYCLE_WDATA_I,
  input wire logic CYCLE_WR_I,
  input wire logic PERIODIC_FLAG_WR_I,
  input wire logic PERIODIC_FLAG_WDATA_I,
  input wire logic [CYCLE_W-1:0] INTERRUPT_CYCLE_SELECT_O,
  input wire logic ALARM_HIT_FLAG_O,
  input wire logic PERIODIC_HIT_FLAG_O,
  input wire logic IRQ_OUT_N_O,
  input wire logic IRQ_OE_O
);
  // ----------
  // Helpers
  // ----------
  logic hit;
  assign hit = CAL_WEEKDAY_I == ALARM_WEEKDAY_I && CAL_HOUR_I == ALARM_HOUR_I
    && CAL_MINUTE_I == ALARM_MINUTE_I;
  default clocking @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);
  // ----------
  // Checks
  // ----------
  reset_quiet_a: assert property ($fell(RESET_I) |-> IRQ_OUT_N_O && !IRQ_OE_O)
    else $error("pin not released after reset");
  open_drain_a: assert property (IRQ_OE_O != IRQ_OUT_N_O)
    else $error("enable and level disagree");
  sel_copy_a: assert property (CYCLE_WR_I
    |-> ##2 INTERRUPT_CYCLE_SELECT_O == $past(CYCLE_WDATA_I, 2))
    else $error("cycle select not stored");
  pulse_on_a: assert property ((INTERRUPT_CYCLE_SELECT_O[3] == 1'b0
    && INTERRUPT_CYCLE_SELECT_O[1:0] == 2'h1)[*4] |-> !IRQ_OUT_N_O)
    else $error("fixed low code left pin high");
  // Chip select needs four edges to reach the pin, so five idle samples are asked for
  idle_release_a: assert property ((INTERRUPT_CYCLE_SELECT_O == 4'h0
    && !ALARM_HIT_FLAG_O && !CE_I)[*5] |-> IRQ_OUT_N_O && !IRQ_OE_O)
    else $error("pin held low with no source requesting");
  suppress_idle_a: assert property ((ALARM_OUTPUT_SUPPRESS_I && !CE_I
    && INTERRUPT_CYCLE_SELECT_O == 4'h0)[*5] |-> IRQ_OUT_N_O)
    else $error("suppressed alarm drove pin");
  alarm_pin_a: assert property ((ALARM_HIT_FLAG_O && !ALARM_OUTPUT_SUPPRESS_I)[*2]
    |-> !IRQ_OUT_N_O)
    else $error("alarm flag set but pin high");
  alarm_take_a: assert property (ALARM_ENABLE_I && hit && !$past(hit)
    |-> ##[1:3] ALARM_HIT_FLAG_O)
    else $error("alarm match not taken");
  level_set_a: assert property (INTERRUPT_CYCLE_SELECT_O == 4'h8 && SEC_TICK_I
    |-> ##[1:3] PERIODIC_HIT_FLAG_O)
    else $error("second boundary not flagged");
  level_hold_a: assert property ((PERIODIC_HIT_FLAG_O
    && INTERRUPT_CYCLE_SELECT_O[3])[*2] |-> !IRQ_OUT_N_O)
    else $error("level flag set but pin high");
  flag_clear_a: assert property (PERIODIC_FLAG_WR_I && !PERIODIC_FLAG_WDATA_I
    && !SEC_TICK_I && INTERRUPT_CYCLE_SELECT_O[3] |-> ##[1:3] !PERIODIC_HIT_FLAG_O)
    else $error("level flag not cleared");
endmodule // rtc_irq_sva
bind rtc_irq_top rtc_irq_sva chk_u (.*);

// ==== rtc_irq_top_tb.sv ====
`timescale 1ns/1ps
module rtc_irq_top_tb
  import rtc_irq_pkg::*;
;
  // Short counts keep the run brief; expectations derive from them
  localparam int unsigned FH = 4;
  localparam int unsigned SH = 8;
  localparam int unsigned MH = 10;
  logic CLK_I = 1'b0;
  logic RESET_I = 1'b1;
  logic CE_I = 1'b0;
  logic SEC_TICK_I = 1'b0;
  logic [WDAY_W-1:0] CAL_WEEKDAY_I = '0;
  logic [HOUR_W-1:0] CAL_HOUR_I = '0;
  logic [MIN_W-1:0] CAL_MINUTE_I = '0;
  logic [SEC_W-1:0] CAL_SECOND_I = '0;
  logic [DAY_W-1:0] CAL_DAY_I = '0;
  logic [WDAY_W-1:0] ALARM_WEEKDAY_I = 3'h3;
  logic [HOUR_W-1:0] ALARM_HOUR_I = 6'h12;
  logic [MIN_W-1:0] ALARM_MINUTE_I = 7'h30;
  logic ALARM_ENABLE_I = 1'b0;
  logic ALARM_OUTPUT_SUPPRESS_I = 1'b0;
  logic [CYCLE_W-1:0] CYCLE_WDATA_I = '0;
  logic CYCLE_WR_I = 1'b0;
  logic ALARM_FLAG_WR_I = 1'b0;
  logic ALARM_FLAG_WDATA_I = 1'b0;
  logic PERIODIC_FLAG_WR_I = 1'b0;
  logic PERIODIC_FLAG_WDATA_I = 1'b0;
  logic [CYCLE_W-1:0] INTERRUPT_CYCLE_SELECT_O;
  logic ALARM_HIT_FLAG_O, PERIODIC_HIT_FLAG_O, IRQ_OUT_N_O, IRQ_OE_O, irq_line;
  logic [7:0] lows;
  int checked = 0;
  int n_errors = 0;
  rtc_irq_top #(.FAST_HALF(FH), .SLOW_HALF(SH), .MEAS_HALF(MH), .CE_HOLD_ON(50)) dut_u (.*);
  irq_pullup_host host_u (.oe_i(IRQ_OE_O), .pin_o(irq_line));
  initial
  begin
    forever #25 CLK_I = ~CLK_I;
  end
  // ----------
  // Tasks
  // ----------
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic settle();
    repeat (4) @(posedge CLK_I);
    @(negedge CLK_I);
  endtask
  // k: 0 cycle select, 1 alarm flag, 2 periodic flag
  task automatic wr(input int k, input logic [3:0] v);
    @(posedge CLK_I);
    CYCLE_WDATA_I <= v;
    ALARM_FLAG_WDATA_I <= v[0];
    PERIODIC_FLAG_WDATA_I <= v[0];
    CYCLE_WR_I <= k == 0;
    ALARM_FLAG_WR_I <= k == 1;
    PERIODIC_FLAG_WR_I <= k == 2;
    @(posedge CLK_I);
    {CYCLE_WR_I, ALARM_FLAG_WR_I, PERIODIC_FLAG_WR_I} <= 3'h0;
    settle();
  endtask
  task automatic tick(input logic [6:0] s, m, input logic [5:0] h, d, input logic [2:0] w);
    @(posedge CLK_I);
    {CAL_SECOND_I, CAL_MINUTE_I, CAL_HOUR_I, CAL_DAY_I, CAL_WEEKDAY_I} <= {s, m, h, d, w};
    SEC_TICK_I <= 1'b1;
    @(posedge CLK_I);
    SEC_TICK_I <= 1'b0;
    settle();
  endtask
  task automatic al(input logic en, input logic sup);
    @(posedge CLK_I);
    ALARM_ENABLE_I <= en;
    ALARM_OUTPUT_SUPPRESS_I <= sup;
    settle();
  endtask
  task automatic count(input int n);
    lows = 8'h00;
    repeat (n) @(negedge CLK_I) lows += {7'h0, ~irq_line};
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----------
  // Tests
  // ----------
  initial
  begin
    repeat (10) @(posedge CLK_I);
    RESET_I <= 1'b0;
    settle();
    chk("pin", 8'h1, irq_line);
    chk("select", 8'h0, INTERRUPT_CYCLE_SELECT_O);
    $display("reset test done");
    wr(0, 4'h5);
    chk("pin", 8'h0, irq_line);
    wr(2, 4'h0);
    chk("pflag", 8'h1, PERIODIC_HIT_FLAG_O);
    wr(0, 4'h4);
    chk("pin", 8'h1, irq_line);
    for (int c = 2; c < 4; c++)
    begin
      wr(0, c[3:0]);
      count(c == 2 ? 4 * FH : 4 * SH);
      chk("lows", c == 2 ? 8'(2 * FH) : 8'(2 * SH), lows);
    end
    $display("pulse test done");
    for (int c = 8; c < 16; c++)
    begin
      wr(0, c[3:0]);
      tick(7'h01, 7'h01, 6'h01, 6'h02, 3'h1);
      chk("pflag", {7'h0, c == 8}, PERIODIC_HIT_FLAG_O);
      wr(2, 4'h0);
      tick(7'h00, 7'h00, 6'h00, 6'h01, 3'h0);
      chk("pin", 8'h0, irq_line);
      chk("pflag", 8'h1, PERIODIC_HIT_FLAG_O);
      wr(2, 4'h0);
      chk("pin", 8'h1, irq_line);
    end
    wr(2, 4'h1);
    chk("pin", 8'h0, irq_line);
    wr(2, 4'h0);
    wr(0, 4'h0);
    $display("level test done");
    al(1'b1, 1'b0);
    tick(7'h00, 7'h30, 6'h12, 6'h01, 3'h3);
    chk("pin", 8'h0, irq_line);
    chk("aflag", 8'h1, ALARM_HIT_FLAG_O);
    wr(1, 4'h0);
    chk("pin", 8'h1, irq_line);
    al(1'b1, 1'b1);
    tick(7'h00, 7'h31, 6'h12, 6'h01, 3'h3);
    tick(7'h00, 7'h30, 6'h12, 6'h01, 3'h3);
    chk("aflag", 8'h1, ALARM_HIT_FLAG_O);
    chk("pin", 8'h1, irq_line);
    al(1'b0, 1'b0);
    chk("aflag", 8'h0, ALARM_HIT_FLAG_O);
    al(1'b1, 1'b0);
    chk("pin", 8'h0, irq_line);
    wr(1, 4'h0);
    wr(1, 4'h1);
    chk("pin", 8'h0, irq_line);
    wr(1, 4'h0);
    al(1'b0, 1'b0);
    $display("alarm test done");
    @(posedge CLK_I) CE_I <= 1'b1;
    wr(0, 4'h9);
    tick(7'h00, 7'h00, 6'h00, 6'h01, 3'h0);
    chk("pin", 8'h0, irq_line);
    wr(2, 4'h0);
    wr(0, 4'h0);
    count(12);
    chk("short lows", 8'h0, lows);
    repeat (20) @(negedge CLK_I);
    count(4 * MH);
    chk("meas lows", 8'(2 * MH), lows);
    @(posedge CLK_I) CE_I <= 1'b0;
    $display("measure test done");
    wr(0, 4'h8);
    wr(2, 4'h1);
    chk("pin", 8'h0, irq_line);
    @(posedge CLK_I) RESET_I <= 1'b1;
    @(posedge CLK_I) RESET_I <= 1'b0;
    settle();
    chk("pin", 8'h1, irq_line);
    chk("select", 8'h0, INTERRUPT_CYCLE_SELECT_O);
    chk("pflag", 8'h0, PERIODIC_HIT_FLAG_O);
    $display("mid reset test done");
    report_and_stop();
  end
  initial
  begin
    repeat (20000) @(posedge CLK_I);
    n_errors++;
    report_and_stop();
  end
endmodule // rtc_irq_top_tb
